//--- src/cca_pkg.sv
package cca_pkg;

  // host status byte, bit position 0 is the msb
  localparam logic [7:0] HS_ZERO = 8'h00;
  localparam logic [7:0] HS_ATTN = 8'h80;
  localparam logic [7:0] HS_BUSY = 8'h10;
  localparam logic [7:0] HS_CE = 8'h08;
  localparam logic [7:0] HS_DE = 8'h04;

  // condition codes
  localparam logic [1:0] CC_0 = 2'h0;
  localparam logic [1:0] CC_1 = 2'h1;
  localparam logic [1:0] CC_2 = 2'h2;

  // controller io control word fields (bit 0 of the word is the lsb)
  localparam int CONTROLLER_IO_CONTROL_WORD_FUNC_LO = 8;
  localparam int CONTROLLER_IO_CONTROL_WORD_MOD8_POS = 7;
  localparam int CONTROLLER_IO_CONTROL_WORD_SCAN_POS = 1;
  localparam int CONTROLLER_IO_CONTROL_WORD_RBIT_POS = 0;

  // controller function codes
  localparam logic [2:0] FN_INIT_WRITE = 3'h5;
  localparam logic [2:0] FN_INIT_READ = 3'h6;
  localparam logic [2:0] FN_SENSE = 3'h7;
  localparam logic [2:0] FN_SENSE_LEVEL = 3'h3;
  localparam logic [2:0] FN_CTL_RESET = 3'h4;

  // host command decode fields
  localparam int HC_MBIT_POS = 2;
  localparam logic [1:0] HC_WRITE = 2'h1;
  localparam logic [1:0] HC_READ = 2'h2;
  localparam logic [1:0] HC_CONTROL = 2'h3;
  localparam logic [3:0] HC_SENSE = 4'h4;
  localparam logic [3:0] HC_READ_BWD = 4'hc;

  // adapter status word layout (index = 15 - documented bit number)
  localparam int DSW_REJ = 15;
  localparam int DSW_CTL_STORED = 14;
  localparam int DSW_HOST_STORED = 13;
  localparam int DSW_HALT = 12;
  localparam int DSW_DCHK = 11;
  localparam int DSW_SPROT = 10;
  localparam int DSW_TE = 9;
  localparam int DSW_EOT = 8;

  localparam logic [15:0] WC_MAX = 16'h3fff;
  localparam logic [15:0] WC_ONE = 16'h0001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // transfer phases: 0 cycle steal, 1 high byte, 2 low byte
  localparam logic [1:0] PH_CS = 2'h0;
  localparam logic [1:0] PH_HI = 2'h1;
  localparam logic [1:0] PH_LO = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HWAIT = 3'b001,
    ST_CWAIT = 3'b010,
    ST_LOAD = 3'b011,
    ST_XFER = 3'b100,
    ST_SENSE = 3'b101,
    ST_END = 3'b110,
    ST_HCTL = 3'b111
  } cca_state_e;

  typedef struct packed {
    logic [7:0] status;
    logic [1:0] cc;
  } cca_host_resp_s;

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction : odd_par

endpackage : cca_pkg

//--- src/cca_buf.sv
// 18-bit buffer: two data bytes, each with its own odd parity bit
module cca_buf (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic load_word_i,
  input wire logic [15:0] word_i,
  input wire logic load_hi_i,
  input wire logic load_lo_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] word_o,
  output logic [7:0] hi_o,
  output logic [7:0] lo_o,
  output logic [1:0] par_o
);

  logic [17:0] buf_ff;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || clear_i) begin
      buf_ff <= {1'b1, 8'h00, 1'b1, 8'h00};
    end else if (load_word_i) begin
      buf_ff <= {cca_pkg::odd_par(word_i[15:8]), word_i[15:8],
                 cca_pkg::odd_par(word_i[7:0]), word_i[7:0]};
    end else if (load_hi_i) begin
      buf_ff[17:9] <= {cca_pkg::odd_par(byte_i), byte_i};
    end else if (load_lo_i) begin
      buf_ff[8:0] <= {cca_pkg::odd_par(byte_i), byte_i};
    end
  end

  assign hi_o = buf_ff[16:9];
  assign lo_o = buf_ff[7:0];
  assign word_o = {buf_ff[16:9], buf_ff[7:0]};
  assign par_o = {buf_ff[17], buf_ff[8]};

endmodule : cca_buf

//--- src/cca_ctl.sv
module cca_ctl (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // host channel
  input wire logic host_sel_valid_i,
  output logic host_sel_ready_o,
  input wire logic [7:0] host_cmd_i,
  output logic host_resp_valid_o,
  output cca_pkg::cca_host_resp_s host_resp_o,
  output logic host_end_valid_o,
  output logic [7:0] host_end_status_o,
  input wire logic host_end_accept_i,
  output logic host_attn_o,
  output logic [7:0] host_dout_o,
  output logic host_dout_valid_o,
  input wire logic host_dout_ready_i,
  input wire logic [7:0] host_din_i,
  input wire logic host_din_par_i,
  input wire logic host_din_valid_i,
  output logic host_din_ready_o,
  input wire logic host_count_zero_i,
  input wire logic host_halt_i,
  // controller io bus
  input wire logic ctl_xio_i,
  input wire logic ctl_xio_par_err_i,
  input wire logic [15:0] ctl_controller_io_control_word_i,
  output logic [15:0] ctl_sense_o,
  output logic ctl_sense_valid_o,
  output logic ctl_irq_o,
  output logic ctl_cs_req_o,
  output logic ctl_cs_write_o,
  output logic [15:0] ctl_cs_wdata_o,
  input wire logic ctl_cs_ack_i,
  input wire logic [15:0] ctl_cs_rdata_i,
  input wire logic ctl_cs_par_err_i,
  input wire logic ctl_cs_protect_i,
  input wire logic ctl_chain_i
);

  cca_pkg::cca_state_e state_ff, nxt_state;
  logic [7:0] host_cmd_ff, nxt_host_cmd;
  logic host_stored_ff, nxt_host_stored;
  logic ctl_stored_ff, nxt_ctl_stored;
  logic ctl_dir_rd_ff, nxt_ctl_dir_rd;
  logic scan_ff, nxt_scan;
  logic attn_ack_ff, nxt_attn_ack;
  logic de_pend_ff, nxt_de_pend;
  logic end_attn_ff, nxt_end_attn;
  logic rej_ff, nxt_rej;
  logic halt_ff, nxt_halt;
  logic dchk_ff, nxt_dchk;
  logic sprot_ff, nxt_sprot;
  logic te_ff, nxt_te;
  logic eot_ff, nxt_eot;
  logic hirq_ff, nxt_hirq;
  logic [15:0] wc_ff, nxt_wc;
  logic [1:0] phase_ff, nxt_phase;
  logic resp_valid_ff, nxt_resp_valid;
  cca_pkg::cca_host_resp_s resp_ff, nxt_resp;
  logic sense_valid_ff, nxt_sense_valid;
  logic [15:0] sense_ff, nxt_sense;
  logic do_reset;
  logic buf_clear, buf_load_word, buf_load_hi, buf_load_lo;
  logic [15:0] buf_word_in;

  logic [15:0] buf_word;
  logic [7:0] buf_hi, buf_lo;

  // host command decode
  wire hc_ctrl = (host_cmd_i[1:0] == cca_pkg::HC_CONTROL);
  wire hc_write = (host_cmd_i[1:0] == cca_pkg::HC_WRITE);
  wire hc_rbk = (host_cmd_i[3:0] == cca_pkg::HC_READ_BWD);
  wire hc_rd = (host_cmd_i[1:0] == cca_pkg::HC_READ) || hc_rbk;
  wire hc_sense = (host_cmd_i[3:0] == cca_pkg::HC_SENSE);
  wire hc_m = host_cmd_i[cca_pkg::HC_MBIT_POS];
  wire held_rd = (host_cmd_ff[1:0] == cca_pkg::HC_READ) ||
                 (host_cmd_ff[3:0] == cca_pkg::HC_READ_BWD);
  wire held_wr = (host_cmd_ff[1:0] == cca_pkg::HC_WRITE);
  wire held_ctrl = (host_cmd_ff[1:0] == cca_pkg::HC_CONTROL);

  // controller decode
  wire [2:0] fn = ctl_controller_io_control_word_i[cca_pkg::CONTROLLER_IO_CONTROL_WORD_FUNC_LO +: 3];
  wire rbit = ctl_controller_io_control_word_i[cca_pkg::CONTROLLER_IO_CONTROL_WORD_RBIT_POS];
  wire xio_ok = ctl_xio_i && !ctl_xio_par_err_i;
  wire host_sel = host_sel_valid_i && !ctl_xio_i;
  wire wc_last = (wc_ff == cca_pkg::WC_ONE);
  wire dir_to_ctl = ctl_dir_rd_ff;

  // data path handshakes
  wire out_phase = (phase_ff == cca_pkg::PH_HI) || (phase_ff == cca_pkg::PH_LO);
  wire dout_active = (state_ff == cca_pkg::ST_SENSE) ||
                     ((state_ff == cca_pkg::ST_XFER) && !dir_to_ctl);
  assign host_dout_valid_o = dout_active && out_phase;
  assign host_dout_o = (phase_ff == cca_pkg::PH_HI) ? buf_hi : buf_lo;
  assign host_din_ready_o = (state_ff == cca_pkg::ST_XFER) && dir_to_ctl && out_phase;
  wire dout_take = host_dout_valid_o && host_dout_ready_i;
  wire din_take = host_din_ready_o && host_din_valid_i;
  assign ctl_cs_req_o = (state_ff == cca_pkg::ST_LOAD) ||
                        ((state_ff == cca_pkg::ST_XFER) && (phase_ff == cca_pkg::PH_CS));
  assign ctl_cs_write_o = (state_ff == cca_pkg::ST_XFER) && dir_to_ctl;
  assign ctl_cs_wdata_o = buf_word;
  wire cs_take = ctl_cs_req_o && ctl_cs_ack_i;
  assign host_sel_ready_o = !ctl_xio_i;

  // status word, low byte is the held host command when only it is stored
  wire [7:0] dsw_lo = (host_stored_ff && !ctl_stored_ff) ? host_cmd_ff : buf_lo;
  wire [15:0] adapter_status_word = {rej_ff, ctl_stored_ff, host_stored_ff, halt_ff, dchk_ff,
                     sprot_ff, te_ff, eot_ff, dsw_lo};

  assign ctl_irq_o = rej_ff | halt_ff | dchk_ff | sprot_ff | te_ff | eot_ff | hirq_ff;
  assign host_attn_o = (state_ff == cca_pkg::ST_CWAIT) && !attn_ack_ff;
  assign host_end_valid_o = (state_ff == cca_pkg::ST_END) || de_pend_ff;
  assign host_end_status_o = (state_ff == cca_pkg::ST_END) ?
      (cca_pkg::HS_CE | cca_pkg::HS_DE | (end_attn_ff ? cca_pkg::HS_ATTN : cca_pkg::HS_ZERO)) :
      (de_pend_ff ? cca_pkg::HS_DE : cca_pkg::HS_ZERO);
  assign host_resp_valid_o = resp_valid_ff;
  assign host_resp_o = resp_ff;
  assign ctl_sense_valid_o = sense_valid_ff;
  assign ctl_sense_o = sense_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_host_cmd = host_cmd_ff;
    nxt_host_stored = host_stored_ff;
    nxt_ctl_stored = ctl_stored_ff;
    nxt_ctl_dir_rd = ctl_dir_rd_ff;
    nxt_scan = scan_ff;
    nxt_attn_ack = attn_ack_ff;
    nxt_de_pend = de_pend_ff;
    nxt_end_attn = end_attn_ff;
    nxt_rej = rej_ff;
    nxt_halt = halt_ff;
    nxt_dchk = dchk_ff;
    nxt_sprot = sprot_ff;
    nxt_te = te_ff;
    nxt_eot = eot_ff;
    nxt_hirq = hirq_ff;
    nxt_wc = wc_ff;
    nxt_phase = phase_ff;
    nxt_resp_valid = 1'b0;
    nxt_resp = resp_ff;
    nxt_sense_valid = 1'b0;
    nxt_sense = sense_ff;
    do_reset = 1'b0;
    buf_clear = 1'b0;
    buf_load_word = 1'b0;
    buf_load_hi = 1'b0;
    buf_load_lo = 1'b0;
    buf_word_in = ctl_cs_rdata_i;

    // ending status taken by the host
    if (host_end_accept_i && host_end_valid_o) begin
      if (state_ff == cca_pkg::ST_END) begin
        nxt_state = ctl_stored_ff ? cca_pkg::ST_CWAIT : cca_pkg::ST_IDLE;
      end else begin
        nxt_de_pend = 1'b0;
      end
    end

    // controller instruction; clears come before the hardware sets below
    if (xio_ok) begin
      case (fn)
        cca_pkg::FN_SENSE: begin
          nxt_sense_valid = 1'b1;
          if (!ctl_controller_io_control_word_i[cca_pkg::CONTROLLER_IO_CONTROL_WORD_MOD8_POS]) begin
            nxt_sense = adapter_status_word;
            if (rbit) begin
              nxt_rej = 1'b0;
              nxt_halt = 1'b0;
              nxt_dchk = 1'b0;
              nxt_sprot = 1'b0;
              nxt_te = 1'b0;
              nxt_eot = 1'b0;
              nxt_hirq = 1'b0;
              if (state_ff == cca_pkg::ST_HCTL) begin
                nxt_state = cca_pkg::ST_IDLE;
                nxt_host_stored = 1'b0;
                nxt_de_pend = 1'b1;
                buf_clear = 1'b1;
              end
            end
          end else begin
            nxt_sense = wc_ff;
          end
        end
        cca_pkg::FN_SENSE_LEVEL: begin
          nxt_sense_valid = 1'b1;
          nxt_sense = {15'h0000, ctl_irq_o};
        end
        cca_pkg::FN_CTL_RESET: begin
          do_reset = 1'b1;
        end
        cca_pkg::FN_INIT_WRITE, cca_pkg::FN_INIT_READ: begin
          if (te_ff || ctl_stored_ff ||
              !((state_ff == cca_pkg::ST_IDLE) || (state_ff == cca_pkg::ST_HWAIT)) ||
              ((fn == cca_pkg::FN_INIT_READ) && host_stored_ff && held_rd) ||
              ((fn == cca_pkg::FN_INIT_WRITE) && host_stored_ff && held_wr)) begin
            nxt_rej = 1'b1;
            if (!ctl_stored_ff) begin
              nxt_wc = cca_pkg::WC_MAX;
            end
          end else begin
            nxt_ctl_stored = 1'b1;
            nxt_ctl_dir_rd = (fn == cca_pkg::FN_INIT_READ);
            nxt_scan = ctl_controller_io_control_word_i[cca_pkg::CONTROLLER_IO_CONTROL_WORD_SCAN_POS];
            nxt_attn_ack = 1'b0;
            nxt_state = cca_pkg::ST_LOAD;
            buf_word_in = ctl_controller_io_control_word_i;
            buf_load_word = 1'b1;
          end
        end
        default: begin
          nxt_rej = 1'b1;
          if (!ctl_stored_ff) begin
            nxt_wc = cca_pkg::WC_MAX;
          end
        end
      endcase
    end

    // initial selection from the host
    if (host_sel) begin
      nxt_resp_valid = 1'b1;
      nxt_resp = '{status: cca_pkg::HS_ZERO, cc: cca_pkg::CC_0};
      if (state_ff == cca_pkg::ST_HCTL) begin
        nxt_resp = '{status: cca_pkg::HS_BUSY, cc: cca_pkg::CC_2};
      end else if (de_pend_ff) begin
        nxt_resp = '{status: cca_pkg::HS_BUSY | cca_pkg::HS_DE, cc: cca_pkg::CC_1};
        nxt_de_pend = 1'b0;
      end else if (state_ff == cca_pkg::ST_CWAIT) begin
        if (hc_sense) begin
          nxt_state = cca_pkg::ST_SENSE;
          nxt_phase = cca_pkg::PH_HI;
          nxt_end_attn = 1'b1;
        end else if ((hc_rd && !ctl_dir_rd_ff) || (hc_write && ctl_dir_rd_ff)) begin
          nxt_host_cmd = host_cmd_i;
          nxt_host_stored = 1'b1;
          nxt_state = cca_pkg::ST_XFER;
          nxt_phase = hc_rd ? cca_pkg::PH_CS : cca_pkg::PH_HI;
        end else begin
          nxt_resp = '{status: cca_pkg::HS_BUSY | cca_pkg::HS_ATTN, cc: cca_pkg::CC_1};
          nxt_attn_ack = 1'b1;
        end
      end else if (state_ff == cca_pkg::ST_IDLE) begin
        if (hc_ctrl) begin
          nxt_resp = '{status: cca_pkg::HS_CE, cc: cca_pkg::CC_1};
          nxt_host_cmd = host_cmd_i;
          nxt_host_stored = 1'b1;
          nxt_state = cca_pkg::ST_HCTL;
          nxt_hirq = 1'b1;
        end else if (hc_rd || hc_write) begin
          nxt_host_cmd = host_cmd_i;
          nxt_host_stored = 1'b1;
          nxt_state = cca_pkg::ST_HWAIT;
          nxt_hirq = hc_rbk || !hc_m;
        end else if (hc_sense) begin
          nxt_state = cca_pkg::ST_SENSE;
          nxt_phase = cca_pkg::PH_HI;
          nxt_end_attn = 1'b0;
        end
      end else begin
        nxt_resp = '{status: cca_pkg::HS_BUSY, cc: cca_pkg::CC_2};
      end
    end

    case (state_ff)
      cca_pkg::ST_LOAD: begin
        if (cs_take) begin
          if (ctl_cs_par_err_i) begin
            nxt_dchk = 1'b1;
            if (host_stored_ff) begin
              nxt_te = 1'b1;
              nxt_host_stored = 1'b0;
              nxt_ctl_stored = 1'b0;
              nxt_state = cca_pkg::ST_END;
            end else begin
              nxt_ctl_stored = 1'b0;
              nxt_state = cca_pkg::ST_IDLE;
            end
          end else begin
            nxt_wc = ctl_cs_rdata_i;
            nxt_hirq = 1'b0;
            nxt_state = host_stored_ff ? cca_pkg::ST_XFER : cca_pkg::ST_CWAIT;
            nxt_phase = (host_stored_ff && held_wr) ? cca_pkg::PH_HI : cca_pkg::PH_CS;
          end
        end
      end
      cca_pkg::ST_XFER: begin
        if (host_halt_i) begin
          nxt_halt = 1'b1;
          nxt_te = 1'b1;
        end else if (cs_take && ctl_cs_par_err_i) begin
          nxt_dchk = 1'b1;
          nxt_te = 1'b1;
        end else if (cs_take && dir_to_ctl && ctl_cs_protect_i) begin
          nxt_sprot = 1'b1;
          nxt_te = 1'b1;
        end else if (din_take && (host_din_par_i != cca_pkg::odd_par(host_din_i))) begin
          nxt_dchk = 1'b1;
          nxt_te = 1'b1;
        end else if (cs_take && !dir_to_ctl) begin
          buf_load_word = 1'b1;
          nxt_phase = cca_pkg::PH_HI;
        end else if ((cs_take && dir_to_ctl) || (dout_take && phase_ff == cca_pkg::PH_LO)) begin
          nxt_wc = wc_ff - cca_pkg::WC_ONE;
          nxt_phase = dir_to_ctl ? cca_pkg::PH_HI : cca_pkg::PH_CS;
          if (wc_last) begin
            nxt_eot = nxt_eot || scan_ff;
            if (ctl_chain_i) begin
              nxt_state = cca_pkg::ST_LOAD;
            end else begin
              nxt_te = 1'b1;
            end
          end else if (host_count_zero_i) begin
            nxt_te = 1'b1;
          end
        end else if (din_take || dout_take) begin
          buf_load_hi = din_take && (phase_ff == cca_pkg::PH_HI);
          buf_load_lo = din_take && (phase_ff == cca_pkg::PH_LO);
          nxt_phase = (phase_ff == cca_pkg::PH_HI) ? cca_pkg::PH_LO : cca_pkg::PH_CS;
          if (host_count_zero_i) begin
            nxt_te = 1'b1;
          end
        end
        if (nxt_te && !te_ff) begin
          nxt_host_stored = 1'b0;
          nxt_ctl_stored = 1'b0;
          nxt_end_attn = 1'b0;
          nxt_state = cca_pkg::ST_END;
        end
      end
      cca_pkg::ST_SENSE: begin
        if (dout_take) begin
          if ((phase_ff == cca_pkg::PH_LO) || host_count_zero_i) begin
            nxt_state = cca_pkg::ST_END;
            nxt_phase = cca_pkg::PH_CS;
          end else begin
            nxt_phase = cca_pkg::PH_LO;
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i || do_reset) begin
      state_ff <= cca_pkg::ST_IDLE;
      host_cmd_ff <= 8'h00;
      host_stored_ff <= 1'b0;
      ctl_stored_ff <= 1'b0;
      ctl_dir_rd_ff <= 1'b0;
      scan_ff <= 1'b0;
      attn_ack_ff <= 1'b0;
      de_pend_ff <= 1'b0;
      end_attn_ff <= 1'b0;
      {rej_ff, halt_ff, dchk_ff, sprot_ff, te_ff, eot_ff, hirq_ff} <= 7'h00;
      wc_ff <= cca_pkg::WC_MAX;
      phase_ff <= cca_pkg::PH_CS;
      resp_valid_ff <= 1'b0;
      resp_ff <= '{status: cca_pkg::HS_ZERO, cc: cca_pkg::CC_0};
      sense_valid_ff <= 1'b0;
      sense_ff <= cca_pkg::WORD_ZERO;
    end else begin
      state_ff <= nxt_state;
      host_cmd_ff <= nxt_host_cmd;
      host_stored_ff <= nxt_host_stored;
      ctl_stored_ff <= nxt_ctl_stored;
      ctl_dir_rd_ff <= nxt_ctl_dir_rd;
      scan_ff <= nxt_scan;
      attn_ack_ff <= nxt_attn_ack;
      de_pend_ff <= nxt_de_pend;
      end_attn_ff <= nxt_end_attn;
      {rej_ff, halt_ff, dchk_ff, sprot_ff, te_ff, eot_ff, hirq_ff} <=
          {nxt_rej, nxt_halt, nxt_dchk, nxt_sprot, nxt_te, nxt_eot, nxt_hirq};
      wc_ff <= nxt_wc;
      phase_ff <= nxt_phase;
      resp_valid_ff <= nxt_resp_valid;
      resp_ff <= nxt_resp;
      sense_valid_ff <= nxt_sense_valid;
      sense_ff <= nxt_sense;
    end
  end

  cca_buf u_buf (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i || do_reset),
    .clear_i(buf_clear),
    .load_word_i(buf_load_word),
    .word_i(buf_word_in),
    .load_hi_i(buf_load_hi),
    .load_lo_i(buf_load_lo),
    .byte_i(host_din_i),
    .word_o(buf_word),
    .hi_o(buf_hi),
    .lo_o(buf_lo),
    .par_o()
  );

endmodule : cca_ctl

//--- verif/cca_ctl_sva.sv
module cca_ctl_sva (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic host_sel_valid_i,
  input wire logic ctl_xio_i,
  input wire logic ctl_xio_par_err_i,
  input wire logic [15:0] ctl_controller_io_control_word_i,
  input wire logic host_resp_valid_o,
  input wire logic host_end_valid_o,
  input wire logic host_end_accept_i,
  input wire logic host_attn_o,
  input wire cca_pkg::cca_host_resp_s host_resp_o,
  input wire logic [7:0] host_end_status_o,
  input wire logic ctl_irq_o,
  input wire logic ctl_sense_valid_o,
  input wire logic ctl_cs_req_o,
  input wire logic ctl_cs_write_o,
  input wire logic ctl_cs_ack_i,
  input wire logic ctl_cs_protect_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  wire rv = host_resp_valid_o;
  wire [7:0] st = host_resp_o.status;
  wire [1:0] cc = host_resp_o.cc;
  wire sns = ctl_xio_i && !ctl_xio_par_err_i && ctl_controller_io_control_word_i[10:8] == cca_pkg::FN_SENSE;
  wire prot = ctl_cs_req_o && ctl_cs_ack_i && ctl_cs_write_o && ctl_cs_protect_i;
  sel_answer_a: assert property (host_sel_valid_i && !ctl_xio_i |=> rv)
    else $error("selection not answered");
  ctl_ce_a: assert property (rv && st == cca_pkg::HS_CE |-> cc == cca_pkg::CC_1)
    else $error("channel end without cc1");
  busy_cc2_a: assert property (rv && st == cca_pkg::HS_BUSY |-> cc == cca_pkg::CC_2)
    else $error("busy without cc2");
  busy_de_a: assert property (rv && st == 8'h14 |-> cc == cca_pkg::CC_1)
    else $error("busy and device end without cc1");
  zero_cc0_a: assert property (rv && st == cca_pkg::HS_ZERO |-> cc == cca_pkg::CC_0)
    else $error("zero status without cc0");
  attn_taken_a: assert property (rv && st == 8'h90 |-> !host_attn_o)
    else $error("attention still requested");
  end_drop_a: assert property (host_end_valid_o && host_end_accept_i |=> !host_end_valid_o)
    else $error("ending status not dropped");
  xio_parity_a: assert property (ctl_xio_i && ctl_xio_par_err_i && !ctl_irq_o && !ctl_cs_req_o
    && !host_sel_valid_i |=> !ctl_irq_o && !ctl_sense_valid_o) else $error("bad xio acted");
  sense_pulse_a: assert property (sns |=> ctl_sense_valid_o)
    else $error("sense not answered");
  protect_end_a: assert property (prot |-> ##[1:2] host_end_valid_o && ctl_irq_o
    && host_end_status_o == 8'h0c) else $error("protect did not end");
  ctl_c: cover property (rv && st == cca_pkg::HS_CE);
  prot_c: cover property (prot);
  end_c: cover property (host_end_valid_o && host_end_accept_i);
endmodule : cca_ctl_sva
bind cca_ctl cca_ctl_sva i_cca_ctl_sva (.sys_clk_i, .srst_i, .host_sel_valid_i, .ctl_xio_i,
  .ctl_xio_par_err_i, .ctl_controller_io_control_word_i, .host_resp_valid_o, .host_end_valid_o, .host_end_accept_i,
  .host_attn_o, .host_resp_o, .host_end_status_o, .ctl_irq_o, .ctl_sense_valid_o,
  .ctl_cs_req_o, .ctl_cs_write_o, .ctl_cs_ack_i, .ctl_cs_protect_i);

//--- verif/cca_mem_model.sv
// controller memory behind the cycle-steal channel: first read is the word count
module cca_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic slow_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] wc_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  output logic [15:0] wlast_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_ff;
  logic [7:0] n_ff;
  wire go = req_i && !ack_o && wait_ff == (slow_i ? 2'h3 : 2'h0);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_ff <= 2'h0;
      n_ff <= 8'h00;
      rdata_o <= 16'h0000;
      wlast_o <= 16'h0000;
    end else begin
      ack_o <= go;
      wait_ff <= (req_i && !go && !ack_o) ? wait_ff + 2'h1 : 2'h0;
      // bus released between steals: invert the shown word every cycle
      rdata_o <= ~rdata_o;
      if (go && write_i) wlast_o <= wdata_i;
      if (go && !write_i) begin
        n_ff <= n_ff + 8'h01;
        rdata_o <= (n_ff == 8'h00) ? wc_i : {8'ha5, n_ff};
      end
    end
  end
endmodule : cca_mem_model

//--- verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 0, srst_i = 1, host_sel_valid_i = 0, host_end_accept_i = 0;
  logic host_din_valid_i = 0, ctl_xio_i = 0, ctl_xio_par_err_i = 0, ctl_cs_protect_i = 0;
  logic host_halt_i = 0, ctl_cs_par_err_i = 0;
  logic [7:0] host_cmd_i = 0, host_din_i = 0, host_end_status_o, host_dout_o, es;
  logic [15:0] ctl_controller_io_control_word_i = 0, ctl_cs_rdata_i, wlast, ctl_sense_o, ctl_cs_wdata_o;
  logic host_sel_ready_o, host_resp_valid_o, host_end_valid_o, host_attn_o, host_dout_valid_o;
  logic host_din_ready_o, ctl_sense_valid_o, ctl_irq_o, ctl_cs_req_o, ctl_cs_write_o;
  logic ctl_cs_ack_i;
  cca_pkg::cca_host_resp_s host_resp_o;
  int bad_count = 0, n_tests = 0;
  logic [7:0] q[$];
  cca_ctl i_cca_ctl (.sys_clk_i, .srst_i, .host_sel_valid_i, .host_sel_ready_o, .host_cmd_i,
    .host_resp_valid_o, .host_resp_o, .host_end_valid_o, .host_end_status_o,
    .host_end_accept_i, .host_attn_o, .host_dout_o, .host_dout_valid_o,
    .host_dout_ready_i(1'b1), .host_din_i, .host_din_par_i(~(^host_din_i)),
    .host_din_valid_i, .host_din_ready_o, .host_count_zero_i(1'b0), .host_halt_i,
    .ctl_xio_i, .ctl_xio_par_err_i, .ctl_controller_io_control_word_i, .ctl_sense_o, .ctl_sense_valid_o,
    .ctl_irq_o, .ctl_cs_req_o, .ctl_cs_write_o, .ctl_cs_wdata_o, .ctl_cs_ack_i,
    .ctl_cs_rdata_i, .ctl_cs_par_err_i, .ctl_cs_protect_i, .ctl_chain_i(1'b0));
  cca_mem_model i_cca_mem_model (.clk_i(sys_clk_i), .rst_i(srst_i), .req_i(ctl_cs_req_o),
    .write_i(ctl_cs_write_o), .slow_i(1'b1), .wdata_i(ctl_cs_wdata_o), .wc_i(16'h0002),
    .ack_o(ctl_cs_ack_i), .rdata_o(ctl_cs_rdata_i), .wlast_o(wlast));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rst_dut;
    srst_i = 1;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 0;
  endtask : rst_dut
  task automatic sel(input logic [7:0] c, input logic [9:0] e);
    @(negedge sys_clk_i);
    host_cmd_i = c;
    host_sel_valid_i = 1;
    @(negedge sys_clk_i);
    host_sel_valid_i = 0;
    chk("resp", {host_resp_valid_o, host_resp_o}, {1'b1, e});
  endtask : sel
  task automatic controller_io_instruction(input logic [15:0] w);
    @(negedge sys_clk_i);
    ctl_controller_io_control_word_i = w;
    ctl_xio_i = 1;
    @(negedge sys_clk_i);
    chk("sel_ready", host_sel_ready_o, 0);
    ctl_xio_i = 0;
  endtask : controller_io_instruction
  task automatic sns(input logic [15:0] w, m, e);
    controller_io_instruction(w);
    chk("sense", ctl_sense_o & m, e);
  endtask : sns
  task automatic cs_idle;
    for (int i = 0; i < 60 && ctl_cs_req_o; i++) @(negedge sys_clk_i);
    chk("cs_idle", ctl_cs_req_o, 0);
    if (ctl_cs_req_o) end_sim();
  endtask : cs_idle
  // collect data bytes, feed write bytes, take the ending status
  task automatic pump;
    logic adv;
    adv = 0;
    q.delete();
    for (int i = 0; i < 300; i++) begin
      if (adv) host_din_i = host_din_i + 8'h11;
      adv = host_din_ready_o && host_din_valid_i;
      if (host_dout_valid_o) q.push_back(host_dout_o);
      if (host_end_valid_o) begin
        es = host_end_status_o;
        host_end_accept_i = 1;
        @(negedge sys_clk_i);
        host_end_accept_i = 0;
        return;
      end
      @(negedge sys_clk_i);
    end
    chk("timeout", 0, 1);
    end_sim();
  endtask : pump
  initial begin
    rst_dut();
    sns(16'h0700, 16'hff00, 16'h0000);
    sns(16'h0780, 16'hffff, cca_pkg::WC_MAX);
    ctl_xio_par_err_i = 1;
    controller_io_instruction(16'h0100);
    ctl_xio_par_err_i = 0;
    chk("irq", ctl_irq_o, 0);
    sns(16'h0700, 16'h8000, 16'h0000);
    controller_io_instruction(16'h0100);
    sns(16'h0701, 16'h8000, 16'h8000);
    sel(8'h03, {cca_pkg::HS_CE, cca_pkg::CC_1});
    chk("irq", ctl_irq_o, 1);
    chk("de", host_end_valid_o, 0);
    sel(8'h03, {cca_pkg::HS_BUSY, cca_pkg::CC_2});
    sel(8'h04, {cca_pkg::HS_BUSY, cca_pkg::CC_2});
    sel(8'h02, {cca_pkg::HS_BUSY, cca_pkg::CC_2});
    sns(16'h0701, 16'h60ff, 16'h2003);
    chk("de", {host_end_valid_o, host_end_status_o}, {1'b1, cca_pkg::HS_DE});
    sel(8'h03, {8'h14, cca_pkg::CC_1});
    chk("de", host_end_valid_o, 0);
    for (int k = 0; k < 2; k++) begin
      sel(8'h03, {cca_pkg::HS_CE, cca_pkg::CC_1});
      controller_io_instruction(16'h0701);
      sel(k ? 8'h02 : 8'h04, {8'h14, cca_pkg::CC_1});
    end
    rst_dut();
    sel(8'h06, {cca_pkg::HS_ZERO, cca_pkg::CC_0});
    chk("irq", ctl_irq_o, 0);
    rst_dut();
    sel(8'h02, {cca_pkg::HS_ZERO, cca_pkg::CC_0});
    chk("irq", ctl_irq_o, 1);
    rst_dut();
    controller_io_instruction(16'h6d02);
    cs_idle();
    chk("attn", host_attn_o, 1);
    sel(8'h03, {8'h90, cca_pkg::CC_1});
    chk("attn", host_attn_o, 0);
    sel(8'h03, {8'h90, cca_pkg::CC_1});
    sel(8'h04, {cca_pkg::HS_ZERO, cca_pkg::CC_0});
    pump();
    chk("sense", {q.size() == 2, q[0], q[1]}, {1'b1, 16'h6d02});
    chk("end", es, 8'h8c);
    sel(8'h0c, {cca_pkg::HS_ZERO, cca_pkg::CC_0});
    pump();
    chk("end", es, 8'h0c);
    chk("bytes", q.size(), 4);
    for (int i = 0; i < 4; i++) chk("byte", q[i], i[0] ? i / 2 + 1 : 8'ha5);
    chk("irq", ctl_irq_o, 1);
    sns(16'h0700, 16'h0300, 16'h0300);
    controller_io_instruction(16'h6d00);
    sns(16'h0701, 16'h8000, 16'h8000);
    sns(16'h0700, 16'h0700, 16'h0000);
    // halt, then a cycle-steal parity error, each in a running read
    for (int k = 0; k < 2; k++) begin
      rst_dut();
      controller_io_instruction(16'h6d00);
      cs_idle();
      host_halt_i = !k;
      ctl_cs_par_err_i = k;
      sel(8'h02, {cca_pkg::HS_ZERO, cca_pkg::CC_0});
      pump();
      host_halt_i = 0;
      ctl_cs_par_err_i = 0;
      chk("end", es, 8'h0c);
      sns(16'h0700, 16'h1a00, k ? 16'h0a00 : 16'h1200);
    end
    rst_dut();
    controller_io_instruction(16'h6e00);
    cs_idle();
    host_din_valid_i = 1;
    host_din_i = 8'h12;
    ctl_cs_protect_i = 1;
    sel(8'h01, {cca_pkg::HS_ZERO, cca_pkg::CC_0});
    pump();
    chk("end", es, 8'h0c);
    chk("wlast", wlast, 16'h1223);
    sns(16'h0700, 16'h0600, 16'h0600);
    end_sim();
  end
endmodule : tb
